// [mbh_params.svh]
// timing and field constants for the multiplexed bus host
`ifndef MBH_PARAMS_SVH
`define MBH_PARAMS_SVH
`define MBH_ADDR_SETUP_NS   40
`define MBH_LATCH_LOW_NS    80
`define MBH_STROBE_LOW_NS   120
`define MBH_RECOVER_NS      80
`define MBH_CLK_NS          40
`define MBH_ADDR_SETUP_CYC  ((`MBH_ADDR_SETUP_NS + `MBH_CLK_NS - 1) / `MBH_CLK_NS)
`define MBH_LATCH_LOW_CYC   ((`MBH_LATCH_LOW_NS + `MBH_CLK_NS - 1) / `MBH_CLK_NS)
`define MBH_STROBE_LOW_CYC  ((`MBH_STROBE_LOW_NS + `MBH_CLK_NS - 1) / `MBH_CLK_NS)
`define MBH_RECOVER_CYC     ((`MBH_RECOVER_NS + `MBH_CLK_NS - 1) / `MBH_CLK_NS)
`define MBH_WAIT_MAX_CYC    255
`define MBH_MODE_LOW_BYTE   2'h0
`define MBH_MODE_HIGH_BYTE  2'h1
`endif

// [mbh_pkg.sv]
// types for the multiplexed bus host
package mbh_pkg;
    typedef enum logic [2:0] {
        MBH_CYC_REG_READ   = 3'h0,
        MBH_CYC_REG_WRITE  = 3'h1,
        MBH_CYC_DMA_READ   = 3'h2,
        MBH_CYC_DMA_WRITE  = 3'h3,
        MBH_CYC_VECTOR_ACK = 3'h4
    } mbh_cycle_t;

    typedef struct packed {
        mbh_cycle_t  kind;
        logic [7:0]  addr;
        logic [7:0]  wdata;
    } mbh_req_t;

    typedef struct packed {
        logic [7:0]  rdata;
        logic        timeout;
    } mbh_resp_t;

    typedef enum logic [6:0] {
        MBH_IDLE    = 7'h01,
        MBH_SETUP   = 7'h02,
        MBH_LATCH   = 7'h04,
        MBH_TURN    = 7'h08,
        MBH_STROBE  = 7'h10,
        MBH_HOLD    = 7'h20,
        MBH_RECOVER = 7'h40
    } mbh_state_t;
endpackage

// [mbh_sync.sv]
// two-stage synchroniser bank for device pins
`timescale 1ns/10ps
module mbh_sync #(
    parameter int W = 1
) (
    input  wire logic         ref_clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] stage1_reg;
    logic [W-1:0] stage2_reg;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            // reset to the idle high level of the active-low pins
            stage1_reg <= '1;
            stage2_reg <= '1;
        end else begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
        end
    end

    assign sync_out = stage2_reg;
endmodule

// [mbh_host.sv]
// host controller driving the multiplexed address/data bus of the fifo device
`timescale 1ns/10ps
`include "mbh_params.svh"
module mbh_host (
    input  wire logic              ref_clk,
    input  wire logic              reset,
    input  wire logic              high_byte_mode,
    input  wire logic              req_valid,
    input  wire mbh_pkg::mbh_req_t req,
    output logic                   req_ready,
    output logic                   resp_valid,
    output mbh_pkg::mbh_resp_t     resp,
    output logic                   irq_pending,
    input  wire logic [7:0]        muxed_bus_lines_in,
    output logic [7:0]             muxed_bus_lines_out,
    output logic                   muxed_bus_lines_oe,
    input  wire logic              request_wait_n,
    input  wire logic              interrupt_n,
    output logic                   dma_data_strobe_n,
    output logic                   transfer_strobe_n,
    output logic                   read_not_write,
    output logic                   select_n,
    output logic                   latch_strobe_n,
    output logic                   vector_acknowledge_n,
    output logic                   priority_chain_in,
    output logic [3:0]             register_select_bits,
    output logic                   port_one_cfg_bit0,
    output logic                   port_one_cfg_bit1
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [9:0] pin_sync;
    logic [7:0] bus_s;
    logic       wait_s;
    logic       int_s;

    mbh_sync #(.W(10)) u_sync (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .async_in ({interrupt_n, request_wait_n, muxed_bus_lines_in}),
        .sync_out (pin_sync)
    );
    assign bus_s  = pin_sync[7:0];
    assign wait_s = pin_sync[8];
    assign int_s  = pin_sync[9];

    function automatic logic is_dma(input mbh_pkg::mbh_cycle_t k);
        is_dma = (k == mbh_pkg::MBH_CYC_DMA_READ) || (k == mbh_pkg::MBH_CYC_DMA_WRITE);
    endfunction

    function automatic logic is_read(input mbh_pkg::mbh_cycle_t k);
        is_read = (k == mbh_pkg::MBH_CYC_REG_READ) || (k == mbh_pkg::MBH_CYC_DMA_READ)
                  || (k == mbh_pkg::MBH_CYC_VECTOR_ACK);
    endfunction

    // ------------------------------------------------------------
    // cycle sequencer
    // ------------------------------------------------------------
    mbh_pkg::mbh_state_t state_reg, state_next;
    mbh_pkg::mbh_req_t   cur_reg, cur_next;
    logic [7:0]          cnt_reg, cnt_next;
    logic [7:0]          rdata_reg, rdata_next;
    logic                tout_reg, tout_next;
    logic                rdy_reg, rdy_next;
    logic                rv_reg, rv_next;
    logic [7:0]          dout_reg, dout_next;
    logic                oe_reg, oe_next;
    logic                dstb_reg, dstb_next;
    logic                tstb_reg, tstb_next;
    logic                rw_reg, rw_next;
    logic                sel_reg, sel_next;
    logic                las_reg, las_next;
    logic                vack_reg, vack_next;
    logic [3:0]          rsel_reg, rsel_next;
    logic                irq_reg, irq_next;
    logic                m0_reg, m0_next;
    logic                m1_reg, m1_next;
    logic                chain_reg, chain_next;

    always_comb begin
        state_next = state_reg;
        cur_next   = cur_reg;
        cnt_next   = cnt_reg;
        rdata_next = rdata_reg;
        tout_next  = tout_reg;
        rdy_next   = rdy_reg;
        rv_next    = 1'b0;
        dout_next  = dout_reg;
        oe_next    = oe_reg;
        dstb_next  = dstb_reg;
        tstb_next  = tstb_reg;
        rw_next    = rw_reg;
        sel_next   = sel_reg;
        las_next   = las_reg;
        vack_next  = vack_reg;
        rsel_next  = rsel_reg;
        irq_next   = ~int_s;
        m0_next    = high_byte_mode;
        m1_next    = 1'b0;
        chain_next = !high_byte_mode;
        case (state_reg)
            mbh_pkg::MBH_IDLE: begin
                if (req_valid && rdy_reg) begin
                    cur_next   = req;
                    rdy_next   = 1'b0;
                    tout_next  = 1'b0;
                    cnt_next   = 8'(`MBH_ADDR_SETUP_CYC);
                    rw_next    = is_read(req.kind);
                    oe_next    = 1'b1;
                    dout_next  = req.addr;
                    sel_next   = (req.kind == mbh_pkg::MBH_CYC_VECTOR_ACK);
                    vack_next  = !(req.kind == mbh_pkg::MBH_CYC_VECTOR_ACK)
                                 || high_byte_mode;
                    rsel_next  = high_byte_mode ? req.addr[3:0] : 4'h0;
                    state_next = mbh_pkg::MBH_SETUP;
                end
            end
            mbh_pkg::MBH_SETUP: begin
                cnt_next = cnt_reg - 8'h01;
                if (cnt_reg <= 8'h01) begin
                    las_next   = 1'b0;
                    cnt_next   = 8'(`MBH_LATCH_LOW_CYC);
                    state_next = mbh_pkg::MBH_LATCH;
                end
            end
            mbh_pkg::MBH_LATCH: begin
                cnt_next = cnt_reg - 8'h01;
                if (cnt_reg <= 8'h01) begin
                    las_next   = 1'b1;
                    state_next = mbh_pkg::MBH_TURN;
                end
            end
            mbh_pkg::MBH_TURN: begin
                oe_next   = !rw_reg;
                dout_next = cur_reg.wdata;
                // dma cycles wait for the request line before strobing
                if (!is_dma(cur_reg.kind) || !wait_s) begin
                    if (is_dma(cur_reg.kind)) begin
                        dstb_next = 1'b0;
                    end else begin
                        tstb_next = 1'b0;
                    end
                    cnt_next   = 8'(`MBH_STROBE_LOW_CYC);
                    state_next = mbh_pkg::MBH_STROBE;
                end
            end
            mbh_pkg::MBH_STROBE: begin
                cnt_next = cnt_reg - 8'h01;
                if (cnt_reg <= 8'h01) begin
                    cnt_next   = 8'(`MBH_WAIT_MAX_CYC);
                    state_next = mbh_pkg::MBH_HOLD;
                end
            end
            mbh_pkg::MBH_HOLD: begin
                // cpu cycles stretch while the wait line is low, up to the limit
                if (!is_dma(cur_reg.kind) && !wait_s && cnt_reg != 8'h00) begin
                    cnt_next = cnt_reg - 8'h01;
                end else begin
                    tout_next  = !is_dma(cur_reg.kind) && !wait_s;
                    rdata_next = bus_s;
                    dstb_next  = 1'b1;
                    tstb_next  = 1'b1;
                    cnt_next   = 8'(`MBH_RECOVER_CYC);
                    state_next = mbh_pkg::MBH_RECOVER;
                end
            end
            mbh_pkg::MBH_RECOVER: begin
                oe_next  = 1'b0;
                sel_next = 1'b1;
                vack_next = 1'b1;
                cnt_next = cnt_reg - 8'h01;
                if (cnt_reg <= 8'h01) begin
                    rv_next    = 1'b1;
                    rdy_next   = 1'b1;
                    state_next = mbh_pkg::MBH_IDLE;
                end
            end
            default: begin
                state_next = mbh_pkg::MBH_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_reg <= mbh_pkg::MBH_IDLE;
            cur_reg   <= '0;
            cnt_reg   <= 8'h00;
            rdata_reg <= 8'h00;
            tout_reg  <= 1'b0;
            rdy_reg   <= 1'b1;
            rv_reg    <= 1'b0;
            dout_reg  <= 8'h00;
            oe_reg    <= 1'b0;
            dstb_reg  <= 1'b1;
            tstb_reg  <= 1'b1;
            rw_reg    <= 1'b1;
            sel_reg   <= 1'b1;
            las_reg   <= 1'b1;
            vack_reg  <= 1'b1;
            rsel_reg  <= 4'h0;
            irq_reg   <= 1'b0;
            m0_reg    <= 1'b0;
            m1_reg    <= 1'b0;
            chain_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            cur_reg   <= cur_next;
            cnt_reg   <= cnt_next;
            rdata_reg <= rdata_next;
            tout_reg  <= tout_next;
            rdy_reg   <= rdy_next;
            rv_reg    <= rv_next;
            dout_reg  <= dout_next;
            oe_reg    <= oe_next;
            dstb_reg  <= dstb_next;
            tstb_reg  <= tstb_next;
            rw_reg    <= rw_next;
            sel_reg   <= sel_next;
            las_reg   <= las_next;
            vack_reg  <= vack_next;
            rsel_reg  <= rsel_next;
            irq_reg   <= irq_next;
            m0_reg    <= m0_next;
            m1_reg    <= m1_next;
            chain_reg <= chain_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign req_ready            = rdy_reg;
    assign resp_valid           = rv_reg;
    assign resp                 = '{rdata: rdata_reg, timeout: tout_reg};
    assign irq_pending          = irq_reg;
    assign muxed_bus_lines_out  = dout_reg;
    assign muxed_bus_lines_oe   = oe_reg;
    assign dma_data_strobe_n    = dstb_reg;
    assign transfer_strobe_n    = tstb_reg;
    assign read_not_write       = rw_reg;
    assign select_n             = sel_reg;
    assign latch_strobe_n       = las_reg;
    assign vector_acknowledge_n = vack_reg;
    assign priority_chain_in    = chain_reg;
    assign register_select_bits = rsel_reg;
    assign port_one_cfg_bit0    = m0_reg;
    assign port_one_cfg_bit1    = m1_reg;
endmodule

// [mbh_host_chk.sv]
// concurrent checks on the multiplexed bus host pins
`timescale 1ns/10ps
module mbh_host_chk (
    input wire logic       ref_clk,
    input wire logic       reset,
    input wire logic       req_ready,
    input wire logic       muxed_bus_lines_oe,
    input wire logic       dma_data_strobe_n,
    input wire logic       transfer_strobe_n,
    input wire logic       read_not_write,
    input wire logic       select_n,
    input wire logic       latch_strobe_n,
    input wire logic       vector_acknowledge_n,
    input wire logic       priority_chain_in,
    input wire logic [3:0] register_select_bits,
    input wire logic       port_one_cfg_bit0,
    input wire logic       port_one_cfg_bit1
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    sequence latch_pulse_s;
        !latch_strobe_n [*2] ##1 latch_strobe_n;
    endsequence
    sequence strobe_min_s;
        !transfer_strobe_n [*3];
    endsequence
    strobe_excl_a: assert property (dma_data_strobe_n || transfer_strobe_n)
        else $error("both strobes low");
    read_release_a: assert property (!transfer_strobe_n && read_not_write |-> !muxed_bus_lines_oe)
        else $error("bus driven in read");
    addr_drive_a: assert property (!latch_strobe_n |-> muxed_bus_lines_oe)
        else $error("address not driven");
    latch_width_a: assert property ($fell(latch_strobe_n) |-> latch_pulse_s)
        else $error("latch pulse width");
    strobe_width_a: assert property ($fell(transfer_strobe_n) |-> strobe_min_s)
        else $error("strobe too short");
    latch_hold_a: assert property ($rose(latch_strobe_n) |-> $stable(select_n) && $stable(vector_acknowledge_n))
        else $error("select moved at latch");
    chain_cfg_a: assert property (!port_one_cfg_bit1 && priority_chain_in == !port_one_cfg_bit0)
        else $error("mode pins wrong");
    rsel_zero_a: assert property (!port_one_cfg_bit0 |-> register_select_bits == 4'h0)
        else $error("select bits in low mode");
    idle_quiet_a: assert property (req_ready |-> dma_data_strobe_n && transfer_strobe_n && !muxed_bus_lines_oe)
        else $error("activity while idle");
endmodule
bind mbh_host mbh_host_chk mbh_host_chk_i (.ref_clk(ref_clk), .reset(reset),
    .req_ready(req_ready), .muxed_bus_lines_oe(muxed_bus_lines_oe),
    .dma_data_strobe_n(dma_data_strobe_n), .transfer_strobe_n(transfer_strobe_n),
    .read_not_write(read_not_write), .select_n(select_n), .latch_strobe_n(latch_strobe_n),
    .vector_acknowledge_n(vector_acknowledge_n), .priority_chain_in(priority_chain_in),
    .register_select_bits(register_select_bits), .port_one_cfg_bit0(port_one_cfg_bit0),
    .port_one_cfg_bit1(port_one_cfg_bit1));

// [mbh_dev_model.sv]
// behavioural fifo device answering on the multiplexed bus
`timescale 1ns/10ps
module mbh_dev_model #(
    parameter logic [7:0] VEC = 8'h5C
) (
    input  wire logic       ref_clk,
    input  wire logic [7:0] host_out,
    input  wire logic       host_oe,
    input  wire logic       dstb_n,
    input  wire logic       tstb_n,
    input  wire logic       rw,
    input  wire logic       sel_n,
    input  wire logic       lat_n,
    input  wire logic       ack_n,
    input  wire logic       chain_in,
    input  wire logic [3:0] rsel,
    input  wire logic       cfg0,
    input  wire logic       dma_ready,
    input  wire logic       irq,
    input  wire logic [8:0] wait_cyc,
    output logic [7:0]      bus_in,
    output logic            req_wait_n,
    output logic            int_n
);
    logic [7:0] mem [16];
    logic [7:0] fifo_b, addr_q, last;
    logic       sel_q, ack_q, drv, chain_out;
    logic [1:0] port_two_mode;
    int         ds_lo = 0;
    always @(posedge lat_n) begin
        addr_q = cfg0 ? {4'h0, rsel} : host_out;
        sel_q = !sel_n;
        ack_q = !ack_n && !cfg0;
    end
    assign drv = !host_oe && rw && ((sel_q && !ack_q && !(tstb_n && dstb_n)) ||
                 (ack_q && !tstb_n && chain_in && irq));
    assign bus_in = host_oe ? host_out :
                    drv ? (ack_q ? VEC : !dstb_n ? fifo_b : mem[addr_q[3:0]]) : ~last;
    always @(posedge ref_clk) last <= bus_in;
    always @(posedge tstb_n) if (sel_q && !ack_q && !rw) mem[addr_q[3:0]] = host_out;
    always @(posedge dstb_n) if (sel_q && !rw) fifo_b = host_out;
    always @(posedge ref_clk) ds_lo <= tstb_n ? 0 : ds_lo + 1;
    assign req_wait_n = !(dma_ready || (!tstb_n && ds_lo < wait_cyc));
    assign int_n = !irq;
    assign chain_out = chain_in && !irq;
    // second port mode bits of control word 0, positions arbitrary
    assign port_two_mode = mem[0][1:0];
endmodule

// [fifo_mux_bus_host_port_test.sv]
// self-checking bench for the multiplexed bus host
`timescale 1ns/10ps
module fifo_mux_bus_host_port_test;
    localparam logic [7:0] VEC = 8'h5C;
    logic               ref_clk, reset, high_byte_mode, req_valid, req_ready, resp_valid;
    logic               irq_pending, oe, rwn, intn, dstb, tstb, rw, seln, latn, ackn;
    logic               chain, cfg0, cfg1, dma_ready, irq;
    logic [7:0]         bin, bout;
    logic [3:0]         rsel;
    logic [8:0]         wait_cyc;
    mbh_pkg::mbh_req_t  req;
    mbh_pkg::mbh_resp_t r;
    int                 mismatches, n_checks;
    mbh_host mbh_host_i (.ref_clk(ref_clk), .reset(reset), .high_byte_mode(high_byte_mode),
        .req_valid(req_valid), .req(req), .req_ready(req_ready), .resp_valid(resp_valid),
        .resp(r), .irq_pending(irq_pending), .muxed_bus_lines_in(bin),
        .muxed_bus_lines_out(bout), .muxed_bus_lines_oe(oe), .request_wait_n(rwn),
        .interrupt_n(intn), .dma_data_strobe_n(dstb), .transfer_strobe_n(tstb),
        .read_not_write(rw), .select_n(seln), .latch_strobe_n(latn),
        .vector_acknowledge_n(ackn), .priority_chain_in(chain), .register_select_bits(rsel),
        .port_one_cfg_bit0(cfg0), .port_one_cfg_bit1(cfg1));
    mbh_dev_model #(.VEC(VEC)) mbh_dev_model_i (.ref_clk(ref_clk), .host_out(bout),
        .host_oe(oe), .dstb_n(dstb), .tstb_n(tstb), .rw(rw), .sel_n(seln), .lat_n(latn),
        .ack_n(ackn), .chain_in(chain), .rsel(rsel), .cfg0(cfg0), .dma_ready(dma_ready),
        .irq(irq), .wait_cyc(wait_cyc), .bus_in(bin), .req_wait_n(rwn), .int_n(intn));
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic do_reset(input logic hb);
        reset <= 1'b1;
        high_byte_mode <= hb;
        repeat (5) @(posedge ref_clk);
        reset <= 1'b0;
    endtask
    task automatic bus(input mbh_pkg::mbh_cycle_t k, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge ref_clk);
        req_valid <= 1'b1;
        req <= '{kind: k, addr: a, wdata: d};
        do @(posedge ref_clk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        for (n = 0; n < 700 && resp_valid !== 1'b1; n++) @(posedge ref_clk);
        chk({7'h0, resp_valid}, 8'h01);
    endtask
    task automatic t_regs(input logic hb);
        logic [7:0] a;
        a = hb ? 8'h0C : 8'h03;
        do_reset(hb);
        chk({req_ready, dstb, tstb, latn, oe}, 8'h1E);
        bus(mbh_pkg::MBH_CYC_REG_WRITE, a, {7'h2D, hb});
        bus(mbh_pkg::MBH_CYC_REG_READ, a, 8'h00);
        chk(r.rdata, {7'h2D, hb});
        chk({7'h0, cfg0}, {7'h0, hb});
        $display("register test done");
    endtask
    task automatic t_dma;
        dma_ready <= 1'b1;
        bus(mbh_pkg::MBH_CYC_DMA_WRITE, 8'h00, 8'h3C);
        bus(mbh_pkg::MBH_CYC_DMA_READ, 8'h00, 8'h00);
        dma_ready <= 1'b0;
        chk(r.rdata, 8'h3C);
        $display("dma test done");
    endtask
    task automatic t_wait;
        wait_cyc <= 9'h006;
        bus(mbh_pkg::MBH_CYC_REG_READ, 8'h03, 8'h00);
        chk(r.rdata, 8'h5A);
        chk({7'h0, r.timeout}, 8'h00);
        wait_cyc <= 9'h190;
        bus(mbh_pkg::MBH_CYC_REG_READ, 8'h03, 8'h00);
        chk({7'h0, r.timeout}, 8'h01);
        wait_cyc <= 9'h000;
        $display("wait test done");
    endtask
    task automatic t_irq;
        irq <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk({7'h0, irq_pending}, 8'h01);
        chk({7'h0, mbh_dev_model_i.chain_out}, 8'h00);
        bus(mbh_pkg::MBH_CYC_VECTOR_ACK, 8'h00, 8'h00);
        chk(r.rdata, VEC);
        irq <= 1'b0;
        repeat (4) @(posedge ref_clk);
        chk({7'h0, irq_pending}, 8'h00);
        chk({7'h0, mbh_dev_model_i.chain_out}, 8'h01);
        $display("interrupt test done");
    endtask
    initial begin
        #(40 * 8000);
        mismatches++;
        wrap_up();
    end
    initial begin
        {reset, high_byte_mode, req_valid, dma_ready, irq} = 5'h10;
        req = '0;
        wait_cyc = 9'h000;
        mismatches = 0;
        n_checks = 0;
        t_regs(1'b1);
        t_regs(1'b0);
        t_dma();
        t_wait();
        t_irq();
        wrap_up();
    end
endmodule
